// ### design/tbf_burst_formatter.sv
`timescale 1ns/1ps
`default_nettype none
`include "tbf_defines.svh"

module tbf_burst_formatter
    import tbf_pkg::*;
#(
    parameter int CLK_HZ = `TBF_CLK_HZ,
    parameter int BAUD = `TBF_BAUD,
    parameter int PERIOD_POS = `TBF_PERIOD_POS
)
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_enable,
    input wire logic i_ext_lock,
    input wire logic i_ext_tick,
    input wire logic i_ext_frame,
    input wire logic i_data,
    output logic o_data_req,
    output tbf_field_type o_field,
    output tbf_line_type o_line,
    output logic o_sym_tick,
    output logic o_frame_start,
    output logic o_marker,
    output logic [`TBF_POS_W-1:0] o_position
);

    localparam logic [`TBF_POS_W-1:0] PERIOD_LAST = `TBF_POS_W'(PERIOD_POS);
    localparam logic [`TBF_POS_W-1:0] POS_ONE = 10'h001;

    logic rst_meta;
    logic rst_sync;
    logic tick;

    tbf_state_type state;
    tbf_state_type next_state;
    logic [`TBF_POS_W-1:0] pos;
    logic [`TBF_POS_W-1:0] next_pos;
    logic [4:0] slot;
    logic [4:0] next_slot;
    logic [4:0] sbit;
    logic [4:0] next_sbit;
    logic marker;
    logic next_marker;
    logic parity;
    logic next_parity;
    logic last_pos_mark;
    logic next_last_pos_mark;
    logic realign;
    logic next_realign;
    tbf_line_type line;
    tbf_line_type next_line;
    logic frame_start;
    logic next_frame_start;
    logic [`TBF_POS_W-1:0] position;
    logic [`TBF_POS_W-1:0] next_position;

    tbf_field_type field;
    logic bit_value;
    logic emitting;

    // Release of reset is synchronised; assertion stays asynchronous
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    tbf_symbol_clock #(
        .CLK_HZ(CLK_HZ),
        .BAUD(BAUD)
    ) u_symbol_clock (
        .i_clk(i_clk),
        .i_rst_n(rst_sync),
        .i_ext_lock(i_ext_lock),
        .i_ext_tick(i_ext_tick),
        .o_tick(tick)
    );

    // Field decode of the position about to be sent
    always_comb
    begin
        field.kind = FLD_SILENT;
        field.slot = 5'h00;
        field.index = 4'h0;
        if (state != ST_BURST)
        begin
            field.kind = FLD_SILENT;
        end
        else if (pos <= `TBF_SYNC_LAST)
        begin
            field.kind = FLD_SYNC;
            field.index = 4'(pos - POS_ONE);
        end
        else if (pos <= `TBF_OVH_LAST)
        begin
            field.kind = FLD_OVERHEAD;
            field.index = 4'(pos - `TBF_OVH_FIRST);
        end
        else if (pos == `TBF_BURST_BITS)
        begin
            field.kind = FLD_PARITY;
        end
        else
        begin
            field.slot = slot;
            if (sbit < `TBF_B1_BITS)
            begin
                field.kind = FLD_B1;
                field.index = sbit[3:0];
            end
            else if (sbit == `TBF_D1_BIT)
            begin
                field.kind = FLD_D1;
            end
            else if (sbit < `TBF_D2_BIT)
            begin
                field.kind = FLD_B2;
                field.index = 4'(sbit - 5'h09);
            end
            else
            begin
                field.kind = FLD_D2;
            end
        end
    end

    // Bit value; user bits pass straight through
    always_comb
    begin
        bit_value = 1'b0;
        emitting = 1'b0;
        unique case (field.kind)
            FLD_SYNC:
            begin
                emitting = 1'b1;
                if (pos == `TBF_SYNC_MARK_POS)
                begin
                    bit_value = 1'b1;
                end
                else if (pos == `TBF_SYNC_TOGGLE_POS)
                begin
                    bit_value = marker;
                end
            end
            FLD_OVERHEAD, FLD_B1, FLD_D1, FLD_B2, FLD_D2:
            begin
                emitting = 1'b1;
                bit_value = i_data;
            end
            FLD_PARITY:
            begin
                emitting = 1'b1;
                bit_value = parity;
            end
            FLD_SILENT:
            begin
                emitting = 1'b0;
            end
        endcase
    end

    assign o_data_req = tick && emitting && (field.kind != FLD_SYNC) && (field.kind != FLD_PARITY);
    assign o_field = field;

    // Frame sequencing, slot counting, parity and line coding
    always_comb
    begin
        next_state = state;
        next_pos = pos;
        next_slot = slot;
        next_sbit = sbit;
        next_marker = marker;
        next_parity = parity;
        next_last_pos_mark = last_pos_mark;
        next_line = line;
        next_frame_start = 1'b0;
        next_position = position;
        next_realign = realign;
        if (tick)
        begin
            // Nothing is on the line while idle, so no position is shown
            next_position = (state == ST_IDLE) ? 10'h000 : pos;
            next_line.pos = 1'b0;
            next_line.neg = 1'b0;
            if (emitting && bit_value)
            begin
                next_line.pos = !last_pos_mark;
                next_line.neg = last_pos_mark;
                next_last_pos_mark = !last_pos_mark;
            end
            if (state == ST_BURST)
            begin
                if (pos == POS_ONE)
                begin
                    next_frame_start = 1'b1;
                    next_parity = bit_value;
                end
                else if (pos < `TBF_BURST_BITS)
                begin
                    next_parity = parity ^ bit_value;
                end
                if (pos == `TBF_OVH_LAST)
                begin
                    next_slot = 5'h00;
                    next_sbit = 5'h00;
                end
                else if (pos >= `TBF_SLOT_FIRST)
                begin
                    if (sbit == `TBF_SLOT_LAST_BIT)
                    begin
                        next_sbit = 5'h00;
                        next_slot = slot + 5'h01;
                    end
                    else
                    begin
                        next_sbit = sbit + 5'h01;
                    end
                end
            end
            unique case (state)
                ST_IDLE:
                begin
                    next_pos = POS_ONE;
                    next_realign = 1'b0;
                    if (i_enable)
                    begin
                        next_state = ST_BURST;
                    end
                end
                ST_BURST:
                begin
                    next_pos = pos + POS_ONE;
                    if (pos == `TBF_BURST_BITS)
                    begin
                        next_state = ST_SPACE;
                    end
                end
                ST_SPACE:
                begin
                    next_pos = pos + POS_ONE;
                    if (pos == PERIOD_LAST || realign)
                    begin
                        // Period closes at PERIOD_LAST, or early at the first space tick once a realign is pending
                        next_pos = POS_ONE;
                        next_realign = 1'b0;
                        next_marker = !marker;
                        next_state = i_enable ? ST_BURST : ST_IDLE;
                    end
                end
                default:
                begin
                    next_state = ST_IDLE;
                    next_pos = POS_ONE;
                end
            endcase
            if (!i_enable && state == ST_IDLE)
            begin
                next_last_pos_mark = 1'b0;
            end
        end
        // Pulse may fall between ticks, so hold it; a new one outlives the consume
        if (i_ext_frame && i_enable)
        begin
            next_realign = 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            state <= ST_IDLE;
            pos <= 10'h001;
            slot <= 5'h00;
            sbit <= 5'h00;
            marker <= 1'b1;
            parity <= 1'b0;
            last_pos_mark <= 1'b0;
            realign <= 1'b0;
            line <= 2'h0;
            frame_start <= 1'b0;
            position <= 10'h000;
        end
        else
        begin
            state <= next_state;
            pos <= next_pos;
            slot <= next_slot;
            sbit <= next_sbit;
            marker <= next_marker;
            parity <= next_parity;
            last_pos_mark <= next_last_pos_mark;
            realign <= next_realign;
            line <= next_line;
            frame_start <= next_frame_start;
            position <= next_position;
        end
    end

    assign o_line = line;
    assign o_sym_tick = tick;
    assign o_frame_start = frame_start;
    assign o_marker = marker;
    assign o_position = position;

endmodule
`default_nettype wire

// ### design/tbf_defines.svh
`ifndef TBF_DEFINES_SVH
`define TBF_DEFINES_SVH

`define TBF_CLK_HZ 100000000
`define TBF_BAUD 320000
`define TBF_ACC_W 32
`define TBF_PERIOD_US 2500
`define TBF_BURST_US 1178
`define TBF_PERIOD_POS ((`TBF_BAUD * `TBF_PERIOD_US) / 1000000)
`define TBF_POS_W 10
`define TBF_BURST_BITS 10'h179
`define TBF_SYNC_LAST 10'h008
`define TBF_SYNC_MARK_POS 10'h001
`define TBF_SYNC_TOGGLE_POS 10'h007
`define TBF_OVH_FIRST 10'h009
`define TBF_OVH_LAST 10'h010
`define TBF_SLOT_FIRST 10'h011
`define TBF_SLOT_COUNT 5'h14
`define TBF_SLOT_LAST_BIT 5'h11
`define TBF_B1_BITS 5'h08
`define TBF_D1_BIT 5'h08
`define TBF_D2_BIT 5'h11

`endif

// ### design/tbf_pkg.sv
package tbf_pkg;

    typedef enum logic [2:0]
    {
        FLD_SYNC = 3'h0,
        FLD_OVERHEAD = 3'h1,
        FLD_B1 = 3'h2,
        FLD_D1 = 3'h3,
        FLD_B2 = 3'h4,
        FLD_D2 = 3'h5,
        FLD_PARITY = 3'h6,
        FLD_SILENT = 3'h7
    } tbf_field_kind_type;

    typedef struct packed
    {
        tbf_field_kind_type kind;
        logic [4:0] slot;
        logic [3:0] index;
    } tbf_field_type;

    typedef struct packed
    {
        logic pos;
        logic neg;
    } tbf_line_type;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'h0,
        ST_BURST = 2'h1,
        ST_SPACE = 2'h2
    } tbf_state_type;

endpackage

// ### design/tbf_symbol_clock.sv
`timescale 1ns/1ps
`default_nettype none
`include "tbf_defines.svh"

module tbf_symbol_clock
    import tbf_pkg::*;
#(
    parameter int CLK_HZ = `TBF_CLK_HZ,
    parameter int BAUD = `TBF_BAUD
)
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ext_lock,
    input wire logic i_ext_tick,
    output logic o_tick
);

    localparam logic [`TBF_ACC_W-1:0] STEP = `TBF_ACC_W'(BAUD);
    localparam logic [`TBF_ACC_W-1:0] WRAP = `TBF_ACC_W'(CLK_HZ);

    logic [`TBF_ACC_W-1:0] acc;
    logic [`TBF_ACC_W-1:0] next_acc;
    logic tick;
    logic next_tick;

    // Fractional divider: 100 MHz over 320 kbaud is not whole, so jitter one cycle
    always_comb
    begin
        next_acc = acc + STEP;
        next_tick = 1'b0;
        if (next_acc >= WRAP)
        begin
            next_acc = next_acc - WRAP;
            next_tick = 1'b1;
        end
        if (i_ext_lock)
        begin
            // Follow the far timing directly, so any offset within tolerance is tracked
            next_acc = '0;
            next_tick = i_ext_tick;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            acc <= '0;
            tick <= 1'b0;
        end
        else
        begin
            acc <= next_acc;
            tick <= next_tick;
        end
    end

    assign o_tick = tick;

endmodule
`default_nettype wire

// ### dv/tbf_burst_formatter_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "tbf_defines.svh"
module tbf_burst_formatter_sva
    import tbf_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic o_data_req,
    input wire tbf_field_type o_field,
    input wire tbf_line_type o_line,
    input wire logic o_sym_tick,
    input wire logic o_frame_start,
    input wire logic o_marker,
    input wire logic [`TBF_POS_W-1:0] o_position
);
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);

    property p_line_legal;
        !(o_line.pos && o_line.neg);
    endproperty
    a_line_legal: assert property (p_line_legal) else $error("both rails pulsed");

    property p_start_pos;
        o_frame_start |-> o_position == 10'h001 && o_line != 2'b00;
    endproperty
    a_start_pos: assert property (p_start_pos) else $error("frame start misplaced");

    property p_sync_space;
        o_position inside {10'h002, 10'h003, 10'h004, 10'h005, 10'h006, 10'h008}
            |-> o_line == 2'b00;
    endproperty
    a_sync_space: assert property (p_sync_space) else $error("sync zero pulsed");

    property p_marker;
        $changed(o_position) && o_position == 10'h007 |-> (o_line != 2'b00) == o_marker;
    endproperty
    a_marker: assert property (p_marker) else $error("marker bit wrong");

    property p_silent;
        o_position > 10'h179 |-> o_line == 2'b00;
    endproperty
    a_silent: assert property (p_silent) else $error("pulse in silent gap");

    // Symbol must not move between position steps
    property p_hold;
        o_position == $past(o_position) |-> $stable(o_line);
    endproperty
    a_hold: assert property (p_hold) else $error("symbol changed mid interval");

    property p_req_gap;
        o_data_req |=> !o_data_req [*2];
    endproperty
    a_req_gap: assert property (p_req_gap) else $error("requests too close");

    property p_req_span;
        o_data_req |-> o_position >= 10'h008 && o_position <= 10'h177;
    endproperty
    a_req_span: assert property (p_req_span) else $error("request outside data");

    property p_req_ovh;
        o_data_req && o_position < 10'h010 |-> o_field.kind == FLD_OVERHEAD;
    endproperty
    a_req_ovh: assert property (p_req_ovh) else $error("overhead field wrong");

    property p_tick_gap;
        o_sym_tick |=> !o_sym_tick [*2];
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("symbol ticks too close");

    property p_req_tick;
        o_data_req |-> o_sym_tick;
    endproperty
    a_req_tick: assert property (p_req_tick) else $error("request off a symbol tick");
endmodule

bind tbf_burst_formatter tbf_burst_formatter_sva u_sva
(
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .o_data_req(o_data_req),
    .o_field(o_field),
    .o_line(o_line),
    .o_sym_tick(o_sym_tick),
    .o_frame_start(o_frame_start),
    .o_marker(o_marker),
    .o_position(o_position)
);
`default_nettype wire

// ### dv/tbf_line_partner.sv
`timescale 1ns/1ps
`default_nettype none
module tbf_line_partner
    import tbf_pkg::*;
(
    input wire logic i_clk,
    input wire logic [9:0] i_position,
    input wire logic i_frame_start,
    input wire tbf_line_type i_line,
    output logic o_ami_err,
    output logic o_par_err
);
    // Last polarity starts negative so the first mark must be positive
    logic last = 1'b0;
    logic ones = 1'b0;
    logic [9:0] pp = 10'h000;
    wire mk = i_line.pos | i_line.neg;

    initial
    begin
        o_ami_err = 1'b0;
        o_par_err = 1'b0;
    end

    always @(posedge i_clk)
    begin
        if (i_position != pp)
        begin
            pp <= i_position;
            ones <= (i_frame_start ? 1'b0 : ones) ^ mk;
            if (i_frame_start && ones)
                o_par_err <= 1'b1;
            if (mk)
            begin
                if (i_line.pos == last || i_line.pos == i_line.neg)
                    o_ami_err <= 1'b1;
                last <= i_line.pos;
            end
        end
    end
endmodule
`default_nettype wire

// ### dv/test_tbf_burst_formatter.sv
`timescale 1ns/1ps
`default_nettype none
module test_tbf_burst_formatter
    import tbf_pkg::*;
;
    localparam int PP = 400;
    logic i_clk = 1'b0;
    logic i_reset_n, i_enable, i_ext_lock, i_ext_frame;
    logic i_ext_tick = 1'b0;
    logic i_data = 1'b0;
    logic step_ok;
    logic o_data_req, o_sym_tick, o_frame_start, o_marker, ami_err, par_err, par;
    tbf_field_type o_field;
    tbf_line_type o_line;
    logic [9:0] o_position;
    logic [9:0] pq = 10'h000;
    int fail_count = 0, n_tests = 0, nf = 0, nf0, tk = 0;
    logic dq[$];
    wire mk = o_line.pos | o_line.neg;

    tbf_burst_formatter #(.BAUD(25000000), .PERIOD_POS(PP)) dut
    (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_enable(i_enable),
        .i_ext_lock(i_ext_lock),
        .i_ext_tick(i_ext_tick),
        .i_ext_frame(i_ext_frame),
        .i_data(i_data),
        .o_data_req(o_data_req),
        .o_field(o_field),
        .o_line(o_line),
        .o_sym_tick(o_sym_tick),
        .o_frame_start(o_frame_start),
        .o_marker(o_marker),
        .o_position(o_position)
    );

    tbf_line_partner far_end
    (
        .i_clk(i_clk),
        .i_position(o_position),
        .i_frame_start(o_frame_start),
        .i_line(o_line),
        .o_ami_err(ami_err),
        .o_par_err(par_err)
    );

    always #5 i_clk = ~i_clk;

    task automatic cmp_bit(input logic got, input logic want);
        n_tests++;
        if (got !== want)
        begin
            fail_count++;
            $display("MISMATCH %0t bit got %b want %b", $time, got, want);
        end
    endtask

    task automatic cmp_fld(input logic [11:0] got, input logic [11:0] want);
        n_tests++;
        if (got !== want)
        begin
            fail_count++;
            $display("MISMATCH %0t field got %h want %h", $time, got, want);
        end
    endtask

    function automatic logic [11:0] exp_fld(input int p);
        int r;
        int i;
        tbf_field_kind_type k;
        r = (p - 17) % 18;
        k = (p < 17) ? FLD_OVERHEAD : (r < 8) ? FLD_B1 : (r == 8) ? FLD_D1 :
            (r == 17) ? FLD_D2 : FLD_B2;
        i = (p < 17) ? p - 9 : (r < 8) ? r : (r > 8 && r < 17) ? r - 9 : 0;
        return {k, (p < 17) ? 5'h00 : 5'((p - 17) / 18), 4'(i)};
    endfunction

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Bounded so a stuck framer ends as a mismatch, not a hang
    task automatic wait_frames(input int n);
        int k;
        repeat (n)
        begin
            k = 0;
            do
            begin
                @(negedge i_clk);
                k++;
            end
            while (o_frame_start !== 1'b1 && k < 4000);
            cmp_bit(o_frame_start, 1'b1);
            @(posedge i_clk);
        end
    endtask

    // Jittered external strobe, 3 to 5 cycles apart
    always @(posedge i_clk)
    begin
        i_data <= 1'($urandom);
        tk <= (tk == 0) ? 2 + int'($urandom % 3) : tk - 1;
        i_ext_tick <= i_ext_lock && tk == 0;
        if (o_data_req)
        begin
            dq.push_back(i_data);
            cmp_fld(o_field, exp_fld(int'(o_position) + 1));
        end
    end

    always @(negedge i_clk)
    begin
        if (o_position !== pq)
        begin
            // Positions step by one; a period closes at its end or at a realigned gap
            step_ok = (o_position == pq + 10'h001) || (o_position == 10'h000 && pq == 10'(PP));
            step_ok |= o_position == 10'h001 && pq inside {10'h000, 10'h17a, 10'(PP)};
            cmp_bit(step_ok, 1'b1);
            pq = o_position;
            if (pq == 10'h001)
            begin
                nf++;
                par = 1'b0;
            end
            if (pq <= 10'h008)
                cmp_bit(mk, pq == 10'h001 || (pq == 10'h007 && nf[0]));
            else if (pq <= 10'h178)
                cmp_bit(mk, dq.size() > 0 ? dq.pop_front() : 1'bx);
            else if (pq == 10'h179)
                cmp_bit(mk, par);
            else
                cmp_bit(mk, 1'b0);
            par ^= mk;
        end
    end

    initial
    begin
        void'($urandom(98138));
        i_reset_n = 1'b0;
        i_enable = 1'b0;
        i_ext_lock = 1'b0;
        i_ext_frame = 1'b0;
        repeat (4) @(posedge i_clk);
        i_reset_n <= 1'b1;
        i_enable <= 1'b1;
        wait_frames(2);
        i_ext_lock <= 1'b1;
        wait_frames(2);
        i_ext_frame <= 1'b1;
        @(posedge i_clk);
        i_ext_frame <= 1'b0;
        wait_frames(2);
        nf0 = nf;
        i_enable <= 1'b0;
        repeat (8 * PP) @(posedge i_clk);
        cmp_bit(nf == nf0, 1'b1);
        cmp_bit(ami_err, 1'b0);
        cmp_bit(par_err, 1'b0);
        end_sim();
    end

    initial
    begin
        repeat (40000) @(posedge i_clk);
        fail_count++;
        $display("MISMATCH %0t watchdog expired", $time);
        end_sim();
    end
endmodule
`default_nettype wire
